// [hw/srs_startup_seq.sv]
// Startup and reset sequencer: reset merge, power-on reset, sleep interval, clock choice.
`timescale 1ns/1ns
`default_nettype none
`include "srs_defines.svh"
module srs_startup_seq #(
  parameter int unsigned POR_CYCLES = `SRS_POR_TYP_US * `SRS_CLK_MHZ,
  parameter int unsigned CLKREQ_CYCLES = `SRS_CLKREQ_US * `SRS_CLK_MHZ,
  parameter int unsigned SLEEP_CYCLES = `SRS_SLEEP_MIN_US * `SRS_CLK_MHZ
) (
  input wire logic ref_clk_i,                      // 50 MHz timebase.
  input wire logic sys_rst_i,                      // Synchronous reset, active high.
  input wire logic ext_rst_n_i,                    // External reset pin, active low.
  input wire logic core_supply_ok_i,               // Core supply above 0.8 V.
  input wire logic sleep_clock_input_i,            // External sleep clock pin.
  input wire logic compensated_oscillator_i,       // High when a compensated oscillator is fitted.
  output logic global_rst_n_o,                     // Global reset, active low.
  output logic clk_req_o,                          // Clock request to the board.
  output logic sleep_o,                            // Chip held in sleep state.
  output logic startup_go_o,                       // Startup and boot may proceed.
  output logic use_low_power_oscillator_o,         // Internal oscillator is the sleep clock.
  output logic crystal_drive_en_o                  // Drive the crystal pins.
);
  import srs_pkg::*;

  // One increment shared by the power-on counter and the sleep timer.
  function automatic srs_cnt_type cnt_inc(input srs_cnt_type v);
    return v + srs_cnt_type'(1);
  endfunction

  // --------------------------------------------------------------------------
  // Pin synchronisers
  // --------------------------------------------------------------------------
  logic ext_s1_q, ext_s2_q, sup_s1_q, sup_s2_q, cmp_s1_q, cmp_s2_q;

  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      ext_s1_q <= 1'b0;
      ext_s2_q <= 1'b0;
      sup_s1_q <= 1'b0;
      sup_s2_q <= 1'b0;
      cmp_s1_q <= 1'b0;
      cmp_s2_q <= 1'b0;
    end else begin
      ext_s1_q <= ext_rst_n_i;
      ext_s2_q <= ext_s1_q;
      sup_s1_q <= core_supply_ok_i;
      sup_s2_q <= sup_s1_q;
      cmp_s1_q <= compensated_oscillator_i;
      cmp_s2_q <= cmp_s1_q;
    end
  end

  // --------------------------------------------------------------------------
  // Power-on reset and global reset merge
  // --------------------------------------------------------------------------
  srs_cnt_type por_cnt_q, por_cnt_d;
  logic por_done_q, por_done_d;
  logic global_rst_n_q, global_rst_n_d;

  // The typical hold is used; it stays well above the shortest release time.
  always_comb begin
    por_cnt_d = por_cnt_q;
    por_done_d = por_done_q;
    if (!sup_s2_q) begin
      por_cnt_d = '0;
      por_done_d = 1'b0;
    end else if (!por_done_q) begin
      if (por_cnt_q == srs_cnt_type'(POR_CYCLES - 1)) begin
        por_done_d = 1'b1;
      end else begin
        por_cnt_d = cnt_inc(por_cnt_q);
      end
    end
    global_rst_n_d = ext_s2_q & por_done_q;
  end

  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      por_cnt_q <= '0;
      por_done_q <= 1'b0;
      global_rst_n_q <= 1'b0;
    end else begin
      por_cnt_q <= por_cnt_d;
      por_done_q <= por_done_d;
      global_rst_n_q <= global_rst_n_d;
    end
  end

  // --------------------------------------------------------------------------
  // Sleep clock detection
  // --------------------------------------------------------------------------
  logic lpc_present;

  srs_sleep_clk_detect u_lpc_detect (
    .ref_clk_i(ref_clk_i),
    .sys_rst_i(sys_rst_i),
    .restart_i(!global_rst_n_q),
    .sleep_clock_input_i(sleep_clock_input_i),
    .present_o(lpc_present)
  );

  // --------------------------------------------------------------------------
  // Sequencer
  // --------------------------------------------------------------------------
  srs_state_type state_q, state_d;
  srs_cnt_type tmr_q, tmr_d;
  logic clk_req_q, clk_req_d;
  logic go_q, go_d;
  logic losc_q, losc_d;
  logic xtal_q, xtal_d;

  always_comb begin
    state_d = state_q;
    tmr_d = tmr_q;
    clk_req_d = clk_req_q;
    go_d = go_q;
    losc_d = losc_q;
    xtal_d = xtal_q;
    if (!global_rst_n_q) begin
      state_d = SRS_RESET;
      tmr_d = '0;
      clk_req_d = 1'b0;
      go_d = 1'b0;
      losc_d = 1'b0;
      xtal_d = 1'b0;
    end else begin
      // Crystal runs through the sleep interval so it is stable at its end.
      xtal_d = !cmp_s2_q;
      case (state_q)
        SRS_RESET: begin
          state_d = SRS_SLEEP;
          tmr_d = '0;
        end
        SRS_SLEEP: begin
          tmr_d = cnt_inc(tmr_q);
          if (tmr_q == srs_cnt_type'(CLKREQ_CYCLES - 1)) begin
            clk_req_d = 1'b1;
          end
          if (tmr_q == srs_cnt_type'(SLEEP_CYCLES - 1)) begin
            state_d = SRS_RUN;
            go_d = 1'b1;
            losc_d = !lpc_present;
          end
        end
        SRS_RUN: begin
          go_d = 1'b1;
        end
        default: begin
          state_d = SRS_RESET;
          tmr_d = '0;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      state_q <= SRS_RESET;
      tmr_q <= '0;
      clk_req_q <= 1'b0;
      go_q <= 1'b0;
      losc_q <= 1'b0;
      xtal_q <= 1'b0;
    end else begin
      state_q <= state_d;
      tmr_q <= tmr_d;
      clk_req_q <= clk_req_d;
      go_q <= go_d;
      losc_q <= losc_d;
      xtal_q <= xtal_d;
    end
  end

  assign global_rst_n_o = global_rst_n_q;
  assign clk_req_o = clk_req_q;
  assign sleep_o = state_q[1];
  assign startup_go_o = go_q;
  assign use_low_power_oscillator_o = losc_q;
  assign crystal_drive_en_o = xtal_q;

  // --------------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------------
  a_ext_holds_reset: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    !ext_s2_q |=> !global_rst_n_q)
    else $error("global reset released while external reset active");

  a_release_both: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    $rose(global_rst_n_q) |-> $past(ext_s2_q) && $past(por_done_q))
    else $error("global reset released before both sources");

  a_por_duration: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    $rose(por_done_q) |-> $past(por_cnt_q) == srs_cnt_type'(POR_CYCLES - 1) && $past(sup_s2_q))
    else $error("power-on reset released at wrong count");

  a_no_boot_in_reset: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    !global_rst_n_q |=> !go_q && state_q == SRS_RESET)
    else $error("startup active during global reset");

  a_clkreq_time: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    $rose(clk_req_q) |-> tmr_q == srs_cnt_type'(CLKREQ_CYCLES) && state_q == SRS_SLEEP)
    else $error("clock request at wrong time");

  a_sleep_min: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    $rose(go_q) |-> $past(tmr_q) == srs_cnt_type'(SLEEP_CYCLES - 1) && clk_req_q)
    else $error("sleep interval shorter than minimum");

  a_osc_select: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    $rose(go_q) |-> losc_q == !$past(lpc_present))
    else $error("sleep clock source chosen wrongly");

  a_crystal_drive: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    global_rst_n_q && !cmp_s2_q |=> xtal_q)
    else $error("crystal not driven without compensated oscillator");

  a_reset_clears: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    !global_rst_n_q |=> !clk_req_q && tmr_q == '0 && !losc_q && !xtal_q)
    else $error("sequencer state not cleared in global reset");
endmodule // srs_startup_seq
`default_nettype wire

// [hw/srs_defines.svh]
// Constants of the startup and reset sequencer.
// Functional notes
// - Global reset is active while the external reset pin or the internal power-on reset is active.
// - Global reset releases only when the later of the two reset sources has released.
// - The power-on reset stays active 3 ms after the core supply crosses 0.8 V, at least 1.5 ms.
// - Startup and boot are held off while the external reset pin is active.
// - The clock-request output rises about 120 us after release from global reset.
// - After release the device stays asleep at least 4.2 ms before startup continues.
// - With no clock on the sleep clock input, the internal low-power oscillator is used instead.
// - With no compensated oscillator present, the device drives a crystal on its crystal pins.
`ifndef SRS_DEFINES_SVH
`define SRS_DEFINES_SVH

// ----------------------------------------------------------------------------
// Clock and timing
// ----------------------------------------------------------------------------
`define SRS_CLK_MHZ 50
`define SRS_POR_TYP_US 3000
`define SRS_POR_MIN_US 1500
`define SRS_CLKREQ_US 120
`define SRS_SLEEP_MIN_US 4200
`define SRS_LPC_TIMEOUT_US 40
`define SRS_LPC_TIMEOUT_CYC (`SRS_LPC_TIMEOUT_US * `SRS_CLK_MHZ)
`define SRS_CNT_W 24
`define SRS_LPC_CNT_W 12

// ----------------------------------------------------------------------------
// State codes, one-hot
// ----------------------------------------------------------------------------
`define SRS_ST_RESET 3'h1
`define SRS_ST_SLEEP 3'h2
`define SRS_ST_RUN 3'h4

`endif

// [hw/srs_pkg.sv]
// Types of the startup and reset sequencer.
`include "srs_defines.svh"
package srs_pkg;
  typedef enum logic [2:0] {
    SRS_RESET = `SRS_ST_RESET,
    SRS_SLEEP = `SRS_ST_SLEEP,
    SRS_RUN = `SRS_ST_RUN
  } srs_state_type;
  typedef logic [`SRS_CNT_W-1:0] srs_cnt_type;
endpackage

// [hw/srs_sleep_clk_detect.sv]
// Activity detector for the sleep clock input pin.
`timescale 1ns/1ns
`default_nettype none
`include "srs_defines.svh"
module srs_sleep_clk_detect (
  input wire logic ref_clk_i,           // System clock.
  input wire logic sys_rst_i,           // Synchronous reset, active high.
  input wire logic restart_i,           // Forget history, treat clock as absent.
  input wire logic sleep_clock_input_i, // Raw sleep clock pin.
  output logic present_o                // Edges seen recently.
);
  import srs_pkg::*;

  logic s1_q, s2_q, s3_q;
  logic [`SRS_LPC_CNT_W-1:0] cnt_q, cnt_d;
  logic present_q, present_d;
  logic edge_seen;

  // --------------------------------------------------------------------------
  // Synchroniser, then edge detection on the settled copy only
  // --------------------------------------------------------------------------
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
    end else begin
      s1_q <= sleep_clock_input_i;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  assign edge_seen = s2_q ^ s3_q;

  // A pin stuck at either level counts as absent once the gap passes the timeout.
  always_comb begin
    cnt_d = cnt_q;
    present_d = present_q;
    if (restart_i) begin
      cnt_d = '0;
      present_d = 1'b0;
    end else if (edge_seen) begin
      cnt_d = '0;
      present_d = 1'b1;
    end else if (cnt_q == `SRS_LPC_CNT_W'(`SRS_LPC_TIMEOUT_CYC - 1)) begin
      present_d = 1'b0;
    end else begin
      cnt_d = cnt_q + `SRS_LPC_CNT_W'(1);
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      cnt_q <= '0;
      present_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      present_q <= present_d;
    end
  end

  assign present_o = present_q;
endmodule // srs_sleep_clk_detect
`default_nettype wire

// [test/srs_board_model.sv]
// Board-side model: reset pin, core supply and the external clock sources.
`timescale 1ns/1ns
`default_nettype none
module srs_board_model (
  input wire logic rst_cmd_i,    // Wanted reset pin level.
  input wire logic supply_cmd_i, // Core supply switched on.
  input wire logic sclk_en_i,    // Sleep clock fitted.
  input wire logic cosc_en_i,    // Compensated oscillator fitted.
  output logic ext_rst_n_o,      // Reset pin, active low.
  output logic core_supply_ok_o, // Supply above threshold.
  output logic sleep_clock_o,    // Sleep clock pin.
  output logic cosc_o            // Oscillator fitted.
);
  logic sclk_q = 1'b0;
  // Runs freely once fitted, so it is stable long before the sleep interval ends.
  // A removed clock falls low at its next toggle and then stands still, giving the detector at most that one edge.
  // A half period of nine clocks keeps every toggle off the sampling edge.
  always #180 sclk_q = sclk_en_i ? ~sclk_q : 1'b0;
  assign ext_rst_n_o = rst_cmd_i;
  assign core_supply_ok_o = supply_cmd_i;
  assign sleep_clock_o = sclk_q;
  assign cosc_o = cosc_en_i;
endmodule // srs_board_model
`default_nettype wire

// [test/test_startup_reset_sequencer.sv]
// Self-checking bench for the startup and reset sequencer.
`timescale 1ns/1ns
`default_nettype none
module test_startup_reset_sequencer;
  localparam int POR = 20;
  localparam int CRQ = 5;
  localparam int SLP = 30;
  logic ref_clk_i, sys_rst_i, rst_cmd, supply_cmd, sclk_en, cosc_en;
  logic ext_rst_n, supply_ok, sclk, cosc;
  logic gl, clk_req, sleep, go, losc, xtal;
  int mismatches = 0;
  int n_tests = 0;
  int cycles = 0;
  int n;
  // Rows: compensated oscillator, sleep clock, expected oscillator choice, crystal drive.
  logic [3:0] rows [4] = '{4'b0101, 4'b1100, 4'b0011, 4'b1010};

  srs_board_model u_board (.rst_cmd_i(rst_cmd), .supply_cmd_i(supply_cmd),
    .sclk_en_i(sclk_en), .cosc_en_i(cosc_en), .ext_rst_n_o(ext_rst_n),
    .core_supply_ok_o(supply_ok), .sleep_clock_o(sclk), .cosc_o(cosc));
  srs_startup_seq #(.POR_CYCLES(POR), .CLKREQ_CYCLES(CRQ), .SLEEP_CYCLES(SLP)) dut (
    .ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i), .ext_rst_n_i(ext_rst_n),
    .core_supply_ok_i(supply_ok), .sleep_clock_input_i(sclk),
    .compensated_oscillator_i(cosc), .global_rst_n_o(gl), .clk_req_o(clk_req),
    .sleep_o(sleep), .startup_go_o(go), .use_low_power_oscillator_o(losc),
    .crystal_drive_en_o(xtal));

  task automatic check(input logic seen, input logic exp, input string what);
    n_tests++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] %0t %s saw %b want %b", $time, what, seen, exp);
    end
  endtask

  task automatic end_sim();
    $display("Comparisons %0d, mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic wait_gl(output int k);
    k = 0;
    while (gl !== 1'b1 && k < 100) begin
      @(negedge ref_clk_i);
      k++;
    end
  endtask

  // Walks the whole interval after release, one cycle at a time.
  task automatic seq_check(input logic xp, input logic lp);
    for (int t = 0; t <= SLP + 2; t++) begin
      check(sleep, t >= 1 && t < SLP + 1, "sleep state");
      check(clk_req, t >= 1 + CRQ, "clock request");
      check(go, t >= 1 + SLP, "startup go");
      check(xtal, (t >= 1) & xp, "crystal drive");
      check(losc, (t >= 1 + SLP) & lp, "oscillator choice");
      @(negedge ref_clk_i);
    end
  endtask

  task automatic walk(input logic xp, input logic lp);
    int k;
    rst_cmd = 1'b1;
    wait_gl(k);
    check(k >= 2 && k <= 4, 1'b1, "pin release delay");
    seq_check(xp, lp);
  endtask

  initial begin
    ref_clk_i = 1'b0;
    forever #10 ref_clk_i = ~ref_clk_i;
  end

  always @(posedge ref_clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 2000) begin
      mismatches++;
      end_sim();
    end
  end

  initial begin
    sys_rst_i = 1'b1;
    rst_cmd = 1'b1;
    supply_cmd = 1'b0;
    sclk_en = 1'b1;
    cosc_en = 1'b0;
    repeat (6) @(negedge ref_clk_i);
    check(gl, 1'b0, "reset global");
    check(clk_req, 1'b0, "reset request");
    check(sleep, 1'b0, "reset sleep");
    sys_rst_i = 1'b0;
    // A supply glitch mid-count must restart the whole power-on count.
    supply_cmd = 1'b1;
    repeat (10) @(negedge ref_clk_i);
    supply_cmd = 1'b0;
    repeat (3) @(negedge ref_clk_i);
    supply_cmd = 1'b1;
    wait_gl(n);
    check(n >= POR && n <= POR + 5, 1'b1, "power-on length");
    seq_check(1'b1, 1'b0);
    // Pin still held after the power-on count ends: the pin decides.
    rst_cmd = 1'b0;
    supply_cmd = 1'b0;
    repeat (4) @(negedge ref_clk_i);
    supply_cmd = 1'b1;
    repeat (POR + 8) @(negedge ref_clk_i);
    check(gl, 1'b0, "pin holds reset");
    walk(1'b1, 1'b0);
    foreach (rows[i]) begin
      rst_cmd = 1'b0;
      cosc_en = rows[i][3];
      sclk_en = rows[i][2];
      repeat (12) @(negedge ref_clk_i);
      check(gl, 1'b0, "pin reset");
      check(go, 1'b0, "go in reset");
      walk(rows[i][0], rows[i][1]);
    end
    // Abort in mid-sleep clears everything again.
    rst_cmd = 1'b0;
    repeat (12) @(negedge ref_clk_i);
    rst_cmd = 1'b1;
    wait_gl(n);
    repeat (10) @(negedge ref_clk_i);
    check(clk_req, 1'b1, "request before abort");
    rst_cmd = 1'b0;
    repeat (4) @(negedge ref_clk_i);
    check(clk_req, 1'b0, "request after abort");
    check(sleep, 1'b0, "sleep after abort");
    end_sim();
  end
endmodule // test_startup_reset_sequencer
`default_nettype wire
